// [sfd_pkg.sv]
package sfd_pkg;
  localparam int num_channels = 10;
  localparam int num_dedicated = 5;
  localparam int high_voltage_channel = 0;
  localparam int code_width = 8;
  localparam int hyst_width = 5;

  // fault types
  typedef enum logic [1:0] {
    fault_under = 2'b00,
    fault_over = 2'b01,
    fault_window = 2'b10
  } fault_type_t;

  // detector ranges, bottom / span in millivolts
  typedef enum logic [1:0] {
    range_ultra_low = 2'b00,
    range_low = 2'b01,
    range_mid = 2'b10,
    range_high = 2'b11
  } range_t;
  localparam int range_bottom_mv [4] = '{573, 1250, 2500, 4800};
  localparam int range_span_mv [4] = '{802, 1750, 3500, 9600};
  localparam int code_full_scale = 255;

  // hysteresis ceilings in microvolts per input type
  localparam int hyst_max_high_low_uv = 425000;
  localparam int hyst_max_high_high_uv = 1160000;
  localparam int hyst_max_positive_uv = 212000;
  localparam int hyst_max_dual_uv = 97500;
  localparam logic [4:0] hyst_code_max = 5'h1f;

  // per channel configuration word, one register each
  typedef struct packed {
    logic [5:0] unused;
    logic logic_mode;
    range_t range;
    fault_type_t fault_type;
    logic [hyst_width-1:0] hysteresis_code;
    logic [code_width-1:0] channel_overvoltage_threshold;
    logic [code_width-1:0] channel_undervoltage_threshold;
  } channel_cfg_t;
  localparam logic [31:0] channel_cfg_reset = 32'h0000_ff00;

  // glitch filter timing
  localparam int clock_mhz = 125;
  localparam int glitch_max_us = 100;
  localparam int glitch_max_cycles = glitch_max_us * clock_mhz;
  localparam int filter_count_width = 14;
  localparam logic [6:0] glitch_timeout_reset = 7'h00;

  // register map, byte addresses
  localparam logic [7:0] channel_cfg_base = 8'h00;
  localparam logic [7:0] glitch_timeout_addr = 8'h28;
  localparam logic [7:0] filtered_state_addr = 8'h2c;
  localparam logic [7:0] irq_status_addr = 8'h30;
  localparam logic [7:0] irq_mask_addr = 8'h34;
  localparam logic [7:0] logic_pin_addr = 8'h38;
  localparam logic [9:0] irq_mask_reset = 10'h000;

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage : sfd_pkg

// [supply_fault_detector_logic.sv]
`timescale 1ns/10ps
// Functional notes
// - ten inputs: five dedicated detectors, five dual-function analog or logic
// - each detector flags under, over, or either (out of window)
// - thresholds are 8-bit codes on span times code over 255 plus bottom
// - ranges 0.573/0.802, 1.25/1.75, 2.5/3.5, 4.8/9.6 volts
// - threshold step is range span over 255, so resolution follows range
// - hysteresis acts only while a fault is active, widening the clear point
// - hysteresis is a 5-bit code, at most 31, on the same step
// - hysteresis capped per input type: 425mV/1.16V, 212mV, 97.5mV
// - glitch filter after each comparator, timeout 0 to 100 us
// - pulses shorter than the timeout never reach the filter output
// - longer pulses pass, delayed by the timeout plus one clock cycle
// - dual-function analog has one range only; logic mode has no hysteresis
// - logic-mode inputs use the same glitch filter
module supply_fault_detector_logic
  import sfd_pkg::*;
#(
  parameter int glitch_cycles_per_us = clock_mhz
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [num_channels*code_width-1:0] input_level_code,
  input wire logic [num_channels-num_dedicated-1:0] dual_function_input,
  output logic [num_channels-1:0] detector_out,
  output logic irq
);

  channel_cfg_t cfg [num_channels];
  logic [6:0] glitch_timeout_us;
  logic [num_channels-1:0] irq_status;
  logic [num_channels-1:0] irq_mask;
  logic [num_channels*code_width-1:0] level_meta, level_sync;
  logic [num_channels-num_dedicated-1:0] pin_meta, pin_sync;
  logic [num_channels-1:0] under_active, over_active, raw;
  logic [num_channels-1:0] filtered, filtered_d;
  logic [filter_count_width-1:0] filt_count [num_channels];
  logic [filter_count_width-1:0] timeout_cycles;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // largest hysteresis code within the input type ceiling
  function automatic logic [4:0] hyst_limit(input int ch, input range_t rg);
    int span_mv;
    int cap_uv;
    int lim;
    span_mv = range_span_mv[rg];
    if (ch == high_voltage_channel) begin
      cap_uv = (rg == range_high) ? hyst_max_high_high_uv
                                  : hyst_max_high_low_uv;
    end else if (ch < num_dedicated) begin
      cap_uv = hyst_max_positive_uv;
    end else begin
      cap_uv = hyst_max_dual_uv;
    end
    lim = (cap_uv * code_full_scale) / (span_mv * 1000);
    if (lim > 31) begin
      lim = 31;
    end
    return lim[4:0];
  endfunction : hyst_limit

  // multi-bit level codes settle slowly in the front end, so two flops suffice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_meta <= '0;
      level_sync <= '0;
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      level_meta <= input_level_code;
      level_sync <= level_meta;
      pin_meta <= dual_function_input;
      pin_sync <= pin_meta;
    end
  end

  // write channel: address and data taken together
  logic wr_go;
  logic [7:0] waddr;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign waddr = s_axi_awaddr[7:0];

  logic wr_hit;
  always_comb begin
    wr_hit = 1'b0;
    if (s_axi_awaddr[31:8] != 24'h000000) begin
      wr_hit = 1'b0;
    end else if (waddr < glitch_timeout_addr && waddr[1:0] == 2'b00) begin
      wr_hit = 1'b1;
    end else if (waddr == glitch_timeout_addr) begin
      wr_hit = 1'b1;
    end else if (waddr == irq_status_addr) begin
      wr_hit = 1'b1;
    end else if (waddr == irq_mask_addr) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < num_channels; i++) begin
        cfg[i] <= channel_cfg_t'(channel_cfg_reset);
      end
      glitch_timeout_us <= glitch_timeout_reset;
      irq_mask <= irq_mask_reset;
    end else if (wr_go && wr_hit) begin
      for (int i = 0; i < num_channels; i++) begin
        if (waddr == channel_cfg_base + 8'(4*i)) begin
          cfg[i] <= channel_cfg_t'(merge_bytes(cfg[i], s_axi_wdata,
                                               s_axi_wstrb));
        end
      end
      if (waddr == glitch_timeout_addr && s_axi_wstrb[0]) begin
        glitch_timeout_us <= (s_axi_wdata[6:0] > 7'(glitch_max_us)) ?
            7'(glitch_max_us) : s_axi_wdata[6:0];
      end
      if (waddr == irq_mask_addr) begin
        irq_mask <= 10'(merge_bytes(32'(irq_mask), s_axi_wdata,
                                    s_axi_wstrb));
      end
    end
  end

  // effective settings per channel
  range_t eff_range [num_channels];
  logic [4:0] eff_hyst [num_channels];
  logic is_logic [num_channels];
  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      is_logic[i] = (i >= num_dedicated) && cfg[i].logic_mode;
      eff_range[i] = (i >= num_dedicated) ? range_ultra_low
                                          : cfg[i].range;
      eff_hyst[i] = cfg[i].hysteresis_code;
      if (eff_hyst[i] > hyst_limit(i, eff_range[i])) begin
        eff_hyst[i] = hyst_limit(i, eff_range[i]);
      end
      if (is_logic[i]) begin
        eff_hyst[i] = 5'h00;
      end
    end
  end

  // comparators on the common code scale of the selected range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      under_active <= '0;
      over_active <= '0;
    end else begin
      for (int i = 0; i < num_channels; i++) begin
        logic [8:0] lvl, uv_clear, ov_th;
        lvl = {1'b0, level_sync[i*code_width +: code_width]};
        uv_clear = {1'b0, cfg[i].channel_undervoltage_threshold}
                   + {4'h0, eff_hyst[i]};
        ov_th = {1'b0, cfg[i].channel_overvoltage_threshold};
        if (!under_active[i]) begin
          under_active[i] <= lvl < {1'b0, cfg[i].channel_undervoltage_threshold};
        end else begin
          under_active[i] <= !(lvl > uv_clear);
        end
        if (!over_active[i]) begin
          over_active[i] <= lvl > ov_th;
        end else begin
          over_active[i] <= lvl + {4'h0, eff_hyst[i]} >= ov_th;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      if (is_logic[i]) begin
        raw[i] = pin_sync[i-num_dedicated];
      end else begin
        case (cfg[i].fault_type)
          fault_under: raw[i] = under_active[i];
          fault_over: raw[i] = over_active[i];
          default: raw[i] = under_active[i] | over_active[i];
        endcase
      end
    end
  end

  // 100 us at 125 MHz exceeds the counter only if the rate is raised
  assign timeout_cycles = filter_count_width'(
      32'(glitch_timeout_us) * 32'(glitch_cycles_per_us));

  // a change must hold for the whole timeout before the output follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filtered <= '0;
      for (int i = 0; i < num_channels; i++) begin
        filt_count[i] <= '0;
      end
    end else begin
      for (int i = 0; i < num_channels; i++) begin
        if (raw[i] == filtered[i]) begin
          filt_count[i] <= '0;
        end else if (filt_count[i] >= timeout_cycles) begin
          filtered[i] <= raw[i];
          filt_count[i] <= '0;
        end else begin
          filt_count[i] <= filt_count[i] + 1'b1;
        end
      end
    end
  end
  assign detector_out = filtered;

  // interrupt: rising edge of a filtered analog fault; set wins over clear
  logic [num_channels-1:0] fault_event, clear_bits;
  always_comb begin
    for (int i = 0; i < num_channels; i++) begin
      fault_event[i] = filtered[i] && !filtered_d[i] && !is_logic[i];
    end
    clear_bits = '0;
    if (wr_go && waddr == irq_status_addr
        && s_axi_awaddr[31:8] == 24'h000000) begin
      clear_bits = 10'(merge_bytes(32'h0, s_axi_wdata,
                                   s_axi_wstrb));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filtered_d <= '0;
      irq_status <= '0;
    end else begin
      filtered_d <= filtered;
      irq_status <= (irq_status & ~clear_bits) | fault_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      logic [7:0] ra;
      ra = s_axi_araddr[7:0];
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= resp_okay;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr[31:8] != 24'h000000 || ra[1:0] != 2'b00) begin
        s_axi_rresp <= resp_slverr;
      end else if (ra < glitch_timeout_addr) begin
        s_axi_rdata <= cfg[ra[5:2]];
      end else if (ra == glitch_timeout_addr) begin
        s_axi_rdata <= 32'(glitch_timeout_us);
      end else if (ra == filtered_state_addr) begin
        s_axi_rdata <= 32'(filtered);
      end else if (ra == irq_status_addr) begin
        s_axi_rdata <= 32'(irq_status);
      end else if (ra == irq_mask_addr) begin
        s_axi_rdata <= 32'(irq_mask);
      end else if (ra == logic_pin_addr) begin
        s_axi_rdata <= 32'(pin_sync);
      end else begin
        s_axi_rresp <= resp_slverr;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : supply_fault_detector_logic

// [sfd_checker_sva.sv]
`timescale 1ns/10ps
module sfd_checker_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] detector_out,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence write_taken;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence read_taken;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  a_write_answer: assert property (write_taken |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_read_answer: assert property (read_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped early");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_bvalid_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid && s_axi_wvalid && s_axi_awready))
    else $error("write response without a write");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    detector_out == 10'h000 && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset left a fault or response");
endmodule : sfd_checker_sva

// [supply_fault_detector_logic_bench.sv]
`timescale 1ns/10ps
module supply_fault_detector_logic_bench;
  import sfd_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [79:0] input_level_code = '0;
  logic [4:0] dual_function_input = '0;
  logic [9:0] detector_out;
  int err_total = 0, total_checks = 0, cycles = 0, n;
  logic [31:0] seed = 32'h0ba90342;
  logic [7:0] u;
  logic [4:0] h;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  // short filter unit keeps the run brief: T is the timeout in cycles
  supply_fault_detector_logic #(.glitch_cycles_per_us(1))
    supply_fault_detector_logic_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .input_level_code, .dual_function_input, .detector_out, .irq);
  always #4 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cfg(logic [7:0] uv, logic [7:0] ov,
      logic [4:0] hy, fault_type_t ty, logic lm);
    channel_cfg_t c;
    c = '{6'h0, lm, range_ultra_low, ty, hy, ov, uv};
    return c;
  endfunction : cfg
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic fail(string what, logic [31:0] e, logic [31:0] g);
    err_total++;
    $display("[FAIL] %s expected %h seen %h", what, e, g);
  endtask : fail
  task automatic cmp_bit(string what, logic e, logic g);
    total_checks++;
    if (g !== e) fail(what, {31'h0, e}, {31'h0, g});
  endtask : cmp_bit
  task automatic cmp_rd(logic [65:0] e);
    total_checks++;
    if ((s_axi_rdata & e[65:34]) !== e[33:2] || s_axi_rresp !== e[1:0])
      fail("read", e[33:2], s_axi_rdata);
  endtask : cmp_rd
  task automatic cmp_wr(logic [1:0] e);
    total_checks++;
    if (s_axi_bresp !== e) fail("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
  endtask : cmp_wr
  // results are judged here, in the order the tasks noted them
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_rd(rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_wr(bq.pop_front());
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic tick(int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  // leading edge avoids driving a valid twice in one time step
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [31:0] a, logic [31:0] d, logic [31:0] m,
      logic [1:0] r);
    @(posedge aclk);
    rq.push_back({m, d & m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic step(int ch, logic [7:0] v, logic e);
    input_level_code[ch*8 +: 8] <= v;
    tick(12);
    cmp_bit("detector", e, detector_out[ch]);
  endtask : step
  task automatic hold(int b, logic e);
    repeat (12) begin
      @(posedge aclk);
      cmp_bit("held", e, detector_out[b]);
    end
  endtask : hold
  initial begin
    tick(4);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(32'(4*i), channel_cfg_reset, '1, resp_okay);
    end
    rd(glitch_timeout_addr, 32'h0, '1, resp_okay);
    rd(filtered_state_addr, 32'h0, '1, resp_okay);
    rd(32'h3c, 32'h0, 32'h0, resp_slverr);
    wr(32'h100, 32'h0, resp_slverr);
    wr(glitch_timeout_addr, 32'hff, resp_okay);
    rd(glitch_timeout_addr, 32'h64, 32'h7f, resp_okay);
    wr(glitch_timeout_addr, 32'h3, resp_okay);
    wr(irq_mask_addr, 32'h2, resp_okay);
    u = 8'(rnd() % 32'hc8) + 8'h8;
    h = 5'(rnd() & 32'h7);
    step(1, 8'hf0, 1'b0);
    wr(32'h4, cfg(u, 8'hff, h, fault_under, 1'b0), resp_okay);
    step(1, u, 1'b0);
    step(1, u - 8'h1, 1'b1);
    cmp_bit("irq", 1'b1, irq);
    step(1, u + h, 1'b1);
    step(1, u + h + 8'h1, 1'b0);
    wr(irq_status_addr, 32'h2, resp_okay);
    cmp_bit("irq", 1'b0, irq);
    wr(32'h8, cfg(8'h0, 8'h64, 5'h0, fault_over, 1'b0), resp_okay);
    input_level_code[23:16] <= 8'h65;
    tick(3);
    input_level_code[23:16] <= 8'h00;
    hold(2, 1'b0);
    input_level_code[23:16] <= 8'h65;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (detector_out[2] !== 1'b1 && n < 30);
    cmp_bit("delay", 1'b1, n == 8);
    cmp_bit("irq", 1'b0, irq);
    rd(irq_status_addr, 32'h4, 32'h4, resp_okay);
    wr(irq_mask_addr, 32'h6, resp_okay);
    cmp_bit("irq", 1'b1, irq);
    wr(irq_status_addr, 32'h4, resp_okay);
    cmp_bit("irq", 1'b0, irq);
    for (int t = 0; t < 3; t++) begin
      wr(32'hc, cfg(8'h32, 8'h96, 5'h0, fault_type_t'(t), 1'b0), resp_okay);
      step(3, 8'h28, t != 1);
      step(3, 8'h64, 1'b0);
      step(3, 8'ha0, t != 0);
    end
    // top range on the high-voltage input caps the hysteresis at 30 codes
    wr(32'h0, cfg(8'h80, 8'hff, 5'h1f, fault_under, 1'b0) | 32'h0180_0000,
       resp_okay);
    step(0, 8'h7f, 1'b1);
    step(0, 8'h9e, 1'b1);
    step(0, 8'h9f, 1'b0);
    wr(32'h18, cfg(8'h0, 8'hff, 5'h0, fault_under, 1'b1), resp_okay);
    dual_function_input[1] <= 1'b1;
    tick(12);
    cmp_bit("logic", 1'b1, detector_out[6]);
    dual_function_input[1] <= 1'b0;
    tick(2);
    dual_function_input[1] <= 1'b1;
    hold(6, 1'b1);
    s_axi_wstrb <= 4'h1;
    wr(32'h24, 32'hffffffab, resp_okay);
    s_axi_wstrb <= 4'hf;
    rd(32'h24, 32'h0000ffab, '1, resp_okay);
    rd(logic_pin_addr, 32'h2, 32'h2, resp_okay);
    rd(irq_status_addr, 32'h0, 32'h40, resp_okay);
    give_verdict();
  end
endmodule : supply_fault_detector_logic_bench
bind supply_fault_detector_logic sfd_checker_sva sfd_checker_sva_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .detector_out, .irq);
